// ===== hw/sxe_dec_if.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// decode results passed from the decoder to the execution core
// ----------------------------------------------------------------
interface sxe_dec_if;
    import sxe_pkg::*;
    logic is_literal_exit;
    logic is_plain_exit;
    logic [DATA_W-1:0] literal;
    modport dec (output is_literal_exit, output is_plain_exit, output literal);
    modport core (input is_literal_exit, input is_plain_exit, input literal);
endinterface : sxe_dec_if

// ===== hw/sxe_decoder.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// opcode match for the two exit instructions
// ----------------------------------------------------------------
module sxe_decoder (
    input wire logic [sxe_pkg::INSTR_W-1:0] instr,
    sxe_dec_if.dec dec
);
    import sxe_pkg::*;

    // match on top bits only; the two bits below them are don't-care
    assign dec.is_literal_exit = (instr[LIT_OP_MSB:LIT_OP_LSB] == LIT_OP_CODE);
    assign dec.literal = instr[LIT_MSB:LIT_LSB];
    // the plain exit is one exact word
    assign dec.is_plain_exit = (instr == RET_OPCODE);
endmodule : sxe_decoder

// ===== hw/sxe_exit_core.sv
`timescale 1ns/1ns
module sxe_exit_core (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [sxe_pkg::INSTR_W-1:0] instr,
    input wire logic [sxe_pkg::PC_W-1:0] stack_top,
    input wire logic [sxe_pkg::FLAG_W-1:0] status_in,
    output logic instr_ready,
    output logic exit_taken,
    output logic pc_load,
    output logic [sxe_pkg::PC_W-1:0] pc_next,
    output logic stack_pop,
    output logic acc_we,
    output logic [sxe_pkg::DATA_W-1:0] acc_wdata,
    output logic fetch_discard,
    output logic status_we,
    output logic [sxe_pkg::FLAG_W-1:0] status_out
);
    import sxe_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // match results travel from the decoder to this core as one bundle
    sxe_dec_if dec_bus ();

    // the decoder sees whatever word stands on the pins this cycle
    sxe_decoder u_dec (
        .instr(instr),
        .dec(dec_bus)
    );

    // ------------------------------------------------------------
    // internal signals
    // ------------------------------------------------------------
    // exit cycle count, sized for the longest exit
    localparam int CYC_W = $clog2(EXIT_CYCLES + 1);
    localparam logic [CYC_W-1:0] CYC_ONE = CYC_W'(1);
    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(EXIT_CYCLES - 1);
    // sequencer state and cycle count
    sxe_state_t state_q;
    sxe_state_t state_d;
    logic [CYC_W-1:0] cyc_q;
    logic [CYC_W-1:0] cyc_d;
    logic in_idle;
    logic in_discard;
    logic last_cyc;
    // acceptance and the kind of exit taken
    logic accept;
    logic lit_hit;
    logic ret_hit;
    logic lit_go;
    logic ret_go;
    logic any_go;
    // program counter reload and stack pop
    logic pc_load_q;
    logic pc_load_d;
    logic [PC_W-1:0] pc_next_q;
    logic [PC_W-1:0] pc_next_d;
    logic stack_pop_q;
    logic stack_pop_d;
    // accumulator write
    logic acc_we_q;
    logic acc_we_d;
    logic [DATA_W-1:0] acc_wdata_q;
    logic [DATA_W-1:0] acc_wdata_d;

    // ------------------------------------------------------------
    // accept
    // ------------------------------------------------------------
    // state decode shared by the handshake, the discard strobe and the count
    assign in_idle = (state_q == SXE_IDLE);
    assign in_discard = (state_q == SXE_DISCARD);
    assign last_cyc = (cyc_q == CYC_LAST);

    // no new word is taken while the fetched word is being discarded
    assign instr_ready = in_idle;
    assign accept = instr_valid & instr_ready;

    // a match only acts once its word is accepted
    assign lit_hit = dec_bus.is_literal_exit;
    assign ret_hit = dec_bus.is_plain_exit;
    assign lit_go = accept & lit_hit;
    assign ret_go = accept & ret_hit;
    assign any_go = lit_go | ret_go;
    assign exit_taken = any_go;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // first cycle executes, the rest discard the word fetched behind the exit
    always_comb begin
        state_d = state_q;
        case (state_q)
            SXE_IDLE: begin
                if (any_go) begin
                    state_d = SXE_DISCARD;
                end
            end
            SXE_DISCARD: begin
                if (last_cyc) begin
                    state_d = SXE_IDLE;
                end
            end
            default: begin
                state_d = SXE_IDLE;
            end
        endcase
    end

    // cycles of the exit in progress, zero when idle
    always_comb begin
        cyc_d = '0;
        if (any_go) begin
            cyc_d = CYC_ONE;
        end else if (in_discard && !last_cyc) begin
            cyc_d = cyc_q + CYC_ONE;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= SXE_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // cycle counter
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_q <= '0;
        end else begin
            cyc_q <= cyc_d;
        end
    end

    // ------------------------------------------------------------
    // program counter and stack
    // ------------------------------------------------------------
    // reload strobe and pop fire in the cycle after acceptance
    assign pc_load_d = any_go;
    assign stack_pop_d = any_go;
    // the return address is caught as the exit is taken, then held
    assign pc_next_d = any_go ? stack_top : pc_next_q;

    // reload strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_load_q <= 1'b0;
        end else begin
            pc_load_q <= pc_load_d;
        end
    end

    // return address
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_next_q <= PC_RST;
        end else begin
            pc_next_q <= pc_next_d;
        end
    end

    // pop strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stack_pop_q <= 1'b0;
        end else begin
            stack_pop_q <= stack_pop_d;
        end
    end

    // registered outputs towards the program counter and the stack
    assign pc_load = pc_load_q;
    assign pc_next = pc_next_q;
    assign stack_pop = stack_pop_q;

    // ------------------------------------------------------------
    // fetch discard
    // ------------------------------------------------------------
    // the word fetched behind the exit is dropped while the pc is reloaded
    assign fetch_discard = in_discard;

    // ------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------
    // only the literal exit writes; the plain exit leaves the accumulator alone
    assign acc_we_d = lit_go;
    assign acc_wdata_d = lit_go ? dec_bus.literal : acc_wdata_q;

    // write strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_we_q <= 1'b0;
        end else begin
            acc_we_q <= acc_we_d;
        end
    end

    // written value
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_wdata_q <= ACC_RST;
        end else begin
            acc_wdata_q <= acc_wdata_d;
        end
    end

    // registered outputs towards the accumulator
    assign acc_we = acc_we_q;
    assign acc_wdata = acc_wdata_q;

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // flags pass through untouched; no write is ever requested
    assign status_we = 1'b0;
    assign status_out = status_in;
endmodule : sxe_exit_core

// ===== hw/sxe_pkg.sv
// ----------------------------------------------------------------
// shared constants for the subroutine exit logic
// ----------------------------------------------------------------
package sxe_pkg;
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int FLAG_W = 3;
    // literal exit: top four bits 1101, bits 9:8 ignored, bits 7:0 literal
    localparam int LIT_OP_MSB = 13;
    localparam int LIT_OP_LSB = 10;
    localparam logic [3:0] LIT_OP_CODE = 4'hD;
    localparam int LIT_MSB = 7;
    localparam int LIT_LSB = 0;
    // plain exit: one fixed word
    localparam logic [INSTR_W-1:0] RET_OPCODE = 14'h0008;
    // instruction cycles taken by either exit
    localparam int EXIT_CYCLES = 2;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    typedef enum {SXE_IDLE, SXE_DISCARD} sxe_state_t;
endpackage : sxe_pkg

// ===== sim/sxe_exit_core_props.sv
`timescale 1ns/1ns
// watches exit timing at the core ports
module sxe_exit_core_props (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [sxe_pkg::INSTR_W-1:0] instr,
    input wire logic [sxe_pkg::PC_W-1:0] stack_top,
    input wire logic [sxe_pkg::FLAG_W-1:0] status_in,
    input wire logic instr_ready,
    input wire logic exit_taken,
    input wire logic pc_load,
    input wire logic [sxe_pkg::PC_W-1:0] pc_next,
    input wire logic stack_pop,
    input wire logic acc_we,
    input wire logic [sxe_pkg::DATA_W-1:0] acc_wdata,
    input wire logic fetch_discard,
    input wire logic status_we,
    input wire logic [sxe_pkg::FLAG_W-1:0] status_out
);
    import sxe_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // decode of the word taken this cycle
    wire tk = instr_valid && instr_ready;
    wire lit = instr[LIT_OP_MSB:LIT_OP_LSB] == LIT_OP_CODE;
    wire ret = instr == RET_OPCODE;
    wire [DATA_W-1:0] lit_byte = instr[LIT_MSB:LIT_LSB];
    chk_lit_write: assert property (tk && lit |=> acc_we && acc_wdata == $past(lit_byte))
        else $error("literal write wrong");
    chk_pc_restore: assert property (tk && (lit || ret) |=> pc_load && stack_pop
        && pc_next == $past(stack_top)) else $error("return address wrong");
    chk_plain_acc: assert property (tk && ret |=> !acc_we)
        else $error("plain exit wrote accumulator");
    chk_discard_slot: assert property (pc_load |-> fetch_discard && !instr_ready)
        else $error("discard cycle missing");
    chk_two_cycles: assert property (fetch_discard |=> instr_ready && !fetch_discard)
        else $error("exit not two cycles");
    chk_exit_pulse: assert property (exit_taken == (tk && (lit || ret)))
        else $error("exit pulse wrong");
    chk_other_word: assert property (tk && !lit && !ret |=> !pc_load && !acc_we)
        else $error("other word acted");
    chk_flags_kept: assert property (!status_we && status_out == status_in)
        else $error("flags changed");
    cover property (tk && lit);
    cover property (tk && ret);
    cover property (fetch_discard && instr_valid);
endmodule : sxe_exit_core_props

bind sxe_exit_core sxe_exit_core_props i_sxe_exit_core_props (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .instr_valid(instr_valid),
    .instr(instr),
    .stack_top(stack_top),
    .status_in(status_in),
    .instr_ready(instr_ready),
    .exit_taken(exit_taken),
    .pc_load(pc_load),
    .pc_next(pc_next),
    .stack_pop(stack_pop),
    .acc_we(acc_we),
    .acc_wdata(acc_wdata),
    .fetch_discard(fetch_discard),
    .status_we(status_we),
    .status_out(status_out)
);

// ===== sim/tb.sv
`timescale 1ns/1ns
module tb;
    import sxe_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [INSTR_W-1:0] instr = '0;
    logic [PC_W-1:0] stack_top = '0, pc_next, e_pc = '0;
    logic [FLAG_W-1:0] status_in = '0, status_out;
    logic [DATA_W-1:0] acc_wdata, e_acc = '0;
    logic instr_ready, exit_taken, pc_load, stack_pop, acc_we, fetch_discard, status_we;
    // model: accepted exits wait in a queue as {literal flag, literal, return address}
    int n_fail = 0, n_compared = 0, seed = 32'h1D1B, r, busy = 0;
    logic [21:0] q_exp[$];
    logic [21:0] ent;
    bit tk = 0, lt = 0, rt = 0, hit = 0, disc = 0, e_lit = 0;
    sxe_exit_core i_sxe_exit_core (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .instr_valid(instr_valid),
        .instr(instr),
        .stack_top(stack_top),
        .status_in(status_in),
        .instr_ready(instr_ready),
        .exit_taken(exit_taken),
        .pc_load(pc_load),
        .pc_next(pc_next),
        .stack_pop(stack_pop),
        .acc_we(acc_we),
        .acc_wdata(acc_wdata),
        .fetch_discard(fetch_discard),
        .status_we(status_we),
        .status_out(status_out)
    );
    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    always #4 core_clk = ~core_clk;
    // the test needs about 410 cycles
    initial begin
        repeat (800) @(posedge core_clk);
        n_fail++;
        close_out();
    end
    task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("BAD %s exp %h seen %h", nm, exp, seen);
            n_fail++;
        end
    endtask : chk
    task automatic close_out;
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // stimulus and model
    // ------------------------------------------------------------
    // random words checked against the model, with a second reset in mid-run
    initial begin
        repeat (10) @(posedge core_clk);
        #1 arst_n = 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge core_clk);
            #1;
            hit = q_exp.size() > 0;
            e_lit = 1'b0;
            if (hit) begin
                ent = q_exp.pop_front();
                e_lit = ent[21];
                e_pc = ent[12:0];
                if (e_lit) e_acc = ent[20:13];
            end
            disc = busy > 0;
            if (busy > 0) busy--;
            chk("pc_load", pc_load, hit);
            chk("pop", stack_pop, hit);
            chk("acc_we", acc_we, e_lit);
            chk("discard", fetch_discard, disc);
            chk("pc_next", pc_next, e_pc);
            chk("acc", acc_wdata, e_acc);
            arst_n = !(i >= 200 && i < 203);
            r = $random(seed);
            instr_valid = (r[14] | r[15]) & arst_n;
            instr = r[13:0];
            if (r[17:16] == 2'h0) instr[LIT_OP_MSB:LIT_OP_LSB] = LIT_OP_CODE;
            if (r[17:16] == 2'h1) instr = RET_OPCODE;
            stack_top = r[30:18];
            status_in = r[2:0];
            if (!arst_n) begin
                q_exp.delete();
                busy = 0;
                disc = 1'b0;
                e_pc = PC_RST;
                e_acc = ACC_RST;
            end
            #1;
            chk("ready", instr_ready, !disc);
            lt = instr[LIT_OP_MSB:LIT_OP_LSB] == LIT_OP_CODE;
            rt = instr == RET_OPCODE;
            tk = instr_valid && !disc && (lt || rt);
            chk("taken", exit_taken, tk);
            chk("flags", {status_we, status_out}, {1'b0, status_in});
            if (tk) begin
                q_exp.push_back({lt, instr[LIT_MSB:LIT_LSB], stack_top});
                busy = EXIT_CYCLES - 1;
            end
        end
        close_out();
    end
endmodule : tb
